// *** verilog/pswc_ctrl_words.sv ***
// Functional notes
// RULE_01: Idle CA outputs: normal, float or weak.
// RULE_02: Weak drive on CA outputs only.
// RULE_03: Float enable set: bit0 picks float/weak.
// RULE_04: Power down off by default, mode ignored.
// RULE_05: Enabled: enter when both clock enables low.
// RULE_06: Bit2 chooses termination and ODT in power down.
// RULE_07: Speed word bits 2..0 give data rate.
// RULE_08: Voltage word bits 1..0 give supply.
// RULE_09: Voltage bit2 selects CA reference source.
// RULE_10: Controller programs voltage word to match supply.
// RULE_11: Drive set per CA, control, clock group; the code fixes control and clock at light.
// RULE_12: Either clock enable high exits power down.
//
// Local design decisions: the address-and-strobe port and the register offsets.
module pswc_ctrl_words #(
    parameter int NUM_CS  = 4,
    parameter int NUM_ODT = 2
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [3:0]         reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output      logic [3:0]         reg_rdata,
    input  wire logic [NUM_CS-1:0]  chip_select_in_n,
    input  wire logic               clk_enable_in0,
    input  wire logic               clk_enable_in1,
    input  wire logic [NUM_ODT-1:0] odt_in,
    output      logic [NUM_ODT-1:0] odt_out,
    output      logic               ca_out_enable_n,
    output      logic [1:0]         ca_drive,
    output      logic [1:0]         ctrl_drive,
    output      logic [1:0]         clk_drive,
    output      logic               input_termination,
    output      logic               power_down,
    output      logic [2:0]         speed_code,
    output      logic               speed_valid,
    output      logic [1:0]         supply_mode,
    output      logic               supply_valid,
    output      logic               ca_reference_voltage
);

    // ------------------------------------------------------------------
    // Control word storage.
    // ------------------------------------------------------------------
    logic [3:0] power_saving_word_reg;
    logic [3:0] operating_speed_word_reg;
    logic [3:0] supply_voltage_word_reg;
    logic [3:0] output_control_word0_reg;
    logic [3:0] ca_drive_word_reg;
    logic       power_down_reg;
    logic       power_down_next;
    logic [3:0] rdata_next;
    logic [1:0] ca_drive_next;
    logic [NUM_ODT-1:0] odt_next;
    pswc_pkg::pswc_ca_mode_type ca_mode;
    pswc_pkg::pswc_config_type  cfg_next;
    pswc_pkg::pswc_config_type  cfg_q;
    pswc_pkg::pswc_drive_type   drv_next;
    pswc_pkg::pswc_drive_type   drv_q;
    logic       all_deselected;
    logic       pd_enable;
    logic       pd_term_off;

    // Words are write-only to the controller; writes to other offsets drop.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_saving_word_reg    <= pswc_pkg::POWER_SAVING_RST;
            operating_speed_word_reg <= pswc_pkg::SPEED_RST;
            supply_voltage_word_reg  <= pswc_pkg::VOLTAGE_RST;
            output_control_word0_reg <= pswc_pkg::OUTPUT_CONTROL_RST;
            ca_drive_word_reg        <= pswc_pkg::CA_DRIVE_RST;
        end else if (reg_write) begin
            if (reg_addr == pswc_pkg::ADDR_POWER_SAVING) begin
                power_saving_word_reg <= reg_wdata;
            end else if (reg_addr == pswc_pkg::ADDR_OPERATING_SPEED) begin
                operating_speed_word_reg <= reg_wdata;
            end else if (reg_addr == pswc_pkg::ADDR_SUPPLY_VOLTAGE) begin
                supply_voltage_word_reg <= reg_wdata;
            end else if (reg_addr == pswc_pkg::ADDR_OUTPUT_CONTROL0) begin
                output_control_word0_reg <= reg_wdata;
            end else if (reg_addr == pswc_pkg::ADDR_CA_DRIVE) begin
                ca_drive_word_reg <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port: only the status word reads back, the rest read zero.
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 4'h0;
        if (reg_read && reg_addr == pswc_pkg::ADDR_STATUS) begin
            rdata_next = {1'b0, ca_mode == pswc_pkg::PSWC_CA_FLOAT,
                          ca_mode == pswc_pkg::PSWC_CA_WEAK, power_down_reg};
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 4'h0;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // CKE power down.
    // ------------------------------------------------------------------
    assign pd_enable   = power_saving_word_reg[pswc_pkg::WORD_BIT3];
    assign pd_term_off = power_saving_word_reg[pswc_pkg::WORD_BIT2];

    // Mode bit is only looked at once power down is enabled.
    always_comb begin
        power_down_next = power_down_reg;
        if (!pd_enable) begin
            power_down_next = 1'b0;                                 // [RULE_04]
        end else if (!clk_enable_in0 && !clk_enable_in1) begin
            power_down_next = 1'b1;                                 // [RULE_05]
        end else if (clk_enable_in0 || clk_enable_in1) begin
            power_down_next = 1'b0;                                 // [RULE_12]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_down_reg <= 1'b0;
        end else begin
            power_down_reg <= power_down_next;
        end
    end

    // Termination and ODT pass-through depend on the mode bit.
    always_comb begin
        odt_next = odt_in;
        if (power_down_next && pd_term_off) begin
            odt_next = '0;                                          // [RULE_06]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            odt_out           <= '0;
            input_termination <= 1'b1;
        end else begin
            odt_out           <= odt_next;
            input_termination <= !(power_down_next && pd_term_off); // [RULE_06]
        end
    end

    // ------------------------------------------------------------------
    // Idle CA output mode.
    // ------------------------------------------------------------------
    assign all_deselected = &chip_select_in_n;

    // Float only when enabled in word 0; bit 0 of the power saving word then chooses weak over float.
    always_comb begin
        ca_mode = pswc_pkg::PSWC_CA_NORMAL;
        if (all_deselected &&
            output_control_word0_reg[pswc_pkg::OC0_FLOAT_EN_BIT]) begin
            if (power_saving_word_reg[pswc_pkg::WORD_BIT0]) begin
                ca_mode = pswc_pkg::PSWC_CA_WEAK;                   // [RULE_03]
            end else begin
                ca_mode = pswc_pkg::PSWC_CA_FLOAT;                  // [RULE_03]
            end
        end
    end

    // Weak drive replaces only the CA group's strength; control and clock
    // groups stay fixed at light.
    always_comb begin
        ca_drive_next = ca_drive_word_reg[1:0];
        if (ca_mode == pswc_pkg::PSWC_CA_WEAK) begin
            ca_drive_next = pswc_pkg::DRIVE_WEAK;                   // [RULE_02]
        end
        drv_next.ca_drive   = ca_drive_next;                        // [RULE_11]
        drv_next.ctrl_drive = pswc_pkg::DRIVE_LIGHT;                // [RULE_11]
        drv_next.clk_drive  = pswc_pkg::DRIVE_LIGHT;                // [RULE_11]
    end

    pswc_sync_ff #(
        .WIDTH ($bits(pswc_pkg::pswc_drive_type)),
        .RST   ('0)
    ) u_drive_ff (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (drv_next),
        .q       (drv_q)
    );

    assign ca_drive   = drv_q.ca_drive;
    assign ctrl_drive = drv_q.ctrl_drive;
    assign clk_drive  = drv_q.clk_drive;

    // Output enable is low while driving; float raises it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ca_out_enable_n <= 1'b0;
        end else begin
            ca_out_enable_n <= (ca_mode == pswc_pkg::PSWC_CA_FLOAT); // [RULE_01]
        end
    end

    // ------------------------------------------------------------------
    // Speed and supply decode; the supply word is trusted as programmed.
    // ------------------------------------------------------------------
    always_comb begin
        cfg_next.speed_code    = operating_speed_word_reg[2:0];          // [RULE_07]
        cfg_next.speed_valid   = operating_speed_word_reg[2:0] <= pswc_pkg::SPEED_2133;
        cfg_next.supply_mode   = supply_voltage_word_reg[1:0];           // [RULE_08]
        cfg_next.supply_valid  = supply_voltage_word_reg[1:0] != pswc_pkg::SUPPLY_RSVD;
        cfg_next.vref_internal = supply_voltage_word_reg[pswc_pkg::WORD_BIT2]; // [RULE_09]
    end

    pswc_sync_ff #(
        .WIDTH ($bits(pswc_pkg::pswc_config_type)),
        .RST   ('0)
    ) u_config_ff (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (cfg_next),
        .q       (cfg_q)
    );

    assign speed_code           = cfg_q.speed_code;
    assign speed_valid          = cfg_q.speed_valid;
    assign supply_mode          = cfg_q.supply_mode;
    assign supply_valid         = cfg_q.supply_valid;
    assign ca_reference_voltage = cfg_q.vref_internal;
    assign power_down           = power_down_reg;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    pd_disabled_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
        !pd_enable |=> !power_down_reg)
        else $error("power down entered while disabled");

    pd_entry_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
        pd_enable && !clk_enable_in0 && !clk_enable_in1 |=> power_down_reg)
        else $error("power down not entered");

    pd_exit_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
        power_down_reg && (clk_enable_in0 || clk_enable_in1) |=> !power_down_reg)
        else $error("power down not left");

    odt_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
        power_down_next && pd_term_off |=> odt_out == '0 && !input_termination)
        else $error("odt not held low");

    odt_follow_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
        !(power_down_next && pd_term_off) |=> odt_out == $past(odt_in))
        else $error("odt not following input");

    ca_float_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_03]
        all_deselected && output_control_word0_reg[1] && !power_saving_word_reg[0]
        |=> ca_out_enable_n)
        else $error("idle outputs not floated");

    ca_weak_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_02]
        ca_mode == pswc_pkg::PSWC_CA_WEAK |=> ca_drive == pswc_pkg::DRIVE_WEAK
        && ctrl_drive == pswc_pkg::DRIVE_LIGHT)
        else $error("weak drive not applied");

    ca_normal_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_01]
        !all_deselected |=> !ca_out_enable_n && ca_drive == $past(ca_drive_word_reg[1:0]))
        else $error("selected outputs not in normal drive");

    speed_word_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
        reg_write && reg_addr == pswc_pkg::ADDR_OPERATING_SPEED
        |=> ##1 speed_code == $past(reg_wdata[2:0], 2))
        else $error("speed code wrong");

    vref_sel_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_09]
        reg_write && reg_addr == pswc_pkg::ADDR_SUPPLY_VOLTAGE
        |=> ##1 ca_reference_voltage == $past(reg_wdata[2], 2)
        && supply_mode == $past(reg_wdata[1:0], 2))                   // [RULE_08]
        else $error("voltage word decode wrong");

    // Reserved rate codes are the two with bits 2 and 1 both set.
    speed_valid_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
        reg_write && reg_addr == pswc_pkg::ADDR_OPERATING_SPEED
        |=> ##1 speed_valid == !($past(reg_wdata[2], 2) && $past(reg_wdata[1], 2)))
        else $error("speed valid flag wrong");

    // Only the all-ones supply code is reserved.
    supply_valid_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_08]
        reg_write && reg_addr == pswc_pkg::ADDR_SUPPLY_VOLTAGE
        |=> ##1 supply_valid == !($past(reg_wdata[1], 2) && $past(reg_wdata[0], 2)))
        else $error("supply valid flag wrong");

    // While power down is disabled the mode bit must change nothing.
    pd_ignored_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
        !pd_enable |=> input_termination && odt_out == $past(odt_in))
        else $error("mode bit acted while disabled");

    // Power down with the mode bit clear keeps termination and ODT alive.
    pd_term_on_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
        power_down_next && !pd_term_off
        |=> input_termination && odt_out == $past(odt_in))
        else $error("termination dropped in power down");

    // Termination is only ever switched off by the mode bit.
    term_on_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
        !pd_term_off |=> input_termination)
        else $error("termination off without mode bit");

    // Weak drive still drives, so the output enable stays low.
    weak_driven_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_02]
        ca_mode == pswc_pkg::PSWC_CA_WEAK |=> !ca_out_enable_n)
        else $error("weak mode floated the outputs");

    // Outside weak drive the CA group keeps its own strength word.
    ca_group_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_11]
        ca_mode != pswc_pkg::PSWC_CA_WEAK |=> ca_drive == $past(ca_drive_word_reg[1:0]))
        else $error("CA group strength wrong");

    // Status reads report the power-down state of the read cycle.
    status_pd_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
        reg_read && reg_addr == pswc_pkg::ADDR_STATUS
        |=> reg_rdata[0] == $past(power_down_reg))
        else $error("status power down bit wrong");

    // The float bit of the status word agrees with the floated outputs.
    status_float_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_03]
        reg_read && reg_addr == pswc_pkg::ADDR_STATUS |=> reg_rdata[2] == ca_out_enable_n)
        else $error("status float bit wrong");

    // Read data live one cycle; without a read strobe the port reads zero.
    rdata_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
        !reg_read |=> reg_rdata == 4'h0)
        else $error("read data outside a read cycle");

    // Coverage of the main scenarios: entry, exit, weak, float, held ODT.
    pd_entry_c: cover property (@(posedge clk) disable iff (!reset_n)
        !power_down_reg ##1 power_down_reg);
    weak_c: cover property (@(posedge clk) disable iff (!reset_n)
        ca_mode == pswc_pkg::PSWC_CA_WEAK);
    float_c: cover property (@(posedge clk) disable iff (!reset_n)
        ca_mode == pswc_pkg::PSWC_CA_FLOAT);
    pd_exit_c: cover property (@(posedge clk) disable iff (!reset_n)
        power_down_reg ##1 !power_down_reg);
    odt_held_c: cover property (@(posedge clk) disable iff (!reset_n)
        power_down_reg && !input_termination);

endmodule // pswc_ctrl_words

// *** verilog/pswc_pkg.sv ***
package pswc_pkg;

    // ------------------------------------------------------------------
    // Register map (word offsets on the plain register port).
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_POWER_SAVING    = 4'h9;
    localparam logic [3:0] ADDR_OPERATING_SPEED = 4'hA;
    localparam logic [3:0] ADDR_SUPPLY_VOLTAGE  = 4'hB;
    localparam logic [3:0] ADDR_OUTPUT_CONTROL0 = 4'h0;
    localparam logic [3:0] ADDR_CA_DRIVE        = 4'h3;
    localparam logic [3:0] ADDR_STATUS          = 4'hC;

    // ------------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------------
    localparam int          WORD_BIT0          = 0;
    localparam int          WORD_BIT1          = 1;
    localparam int          WORD_BIT2          = 2;
    localparam int          WORD_BIT3          = 3;
    localparam int          OC0_FLOAT_EN_BIT   = 1;
    localparam logic [3:0]  POWER_SAVING_RST   = 4'h0;
    localparam logic [3:0]  SPEED_RST          = 4'h0;
    localparam logic [3:0]  VOLTAGE_RST        = 4'h0;
    localparam logic [3:0]  OUTPUT_CONTROL_RST = 4'h0;
    localparam logic [3:0]  CA_DRIVE_RST       = 4'h0;

    // ------------------------------------------------------------------
    // Encodings.
    // ------------------------------------------------------------------
    localparam logic [2:0] SPEED_800      = 3'h0;
    localparam logic [2:0] SPEED_1066     = 3'h1;
    localparam logic [2:0] SPEED_1333     = 3'h2;
    localparam logic [2:0] SPEED_1600     = 3'h3;
    localparam logic [2:0] SPEED_1866     = 3'h4;
    localparam logic [2:0] SPEED_2133     = 3'h5;
    localparam logic [1:0] SUPPLY_1V50    = 2'h0;
    localparam logic [1:0] SUPPLY_1V35    = 2'h1;
    localparam logic [1:0] SUPPLY_1V25    = 2'h2;
    localparam logic [1:0] SUPPLY_RSVD    = 2'h3;

    // Drive code per output group: 2'h0 light, 2'h1 moderate, 2'h2 strong,
    // 2'h3 weak (2.5 to 3 times weaker than light).
    localparam logic [1:0] DRIVE_LIGHT    = 2'h0;
    localparam logic [1:0] DRIVE_WEAK     = 2'h3;

    typedef enum logic [1:0] {
        PSWC_CA_NORMAL,
        PSWC_CA_FLOAT,
        PSWC_CA_WEAK
    } pswc_ca_mode_type;

    // Decoded configuration handed to the output stage.
    typedef struct packed {
        logic [2:0] speed_code;
        logic       speed_valid;
        logic [1:0] supply_mode;
        logic       supply_valid;
        logic       vref_internal;
    } pswc_config_type;

    // Drive strength per output group.
    typedef struct packed {
        logic [1:0] ca_drive;
        logic [1:0] ctrl_drive;
        logic [1:0] clk_drive;
    } pswc_drive_type;

endpackage

// *** verilog/pswc_sync_ff.sv ***
// Plain data register with reset value; one holds all three drive groups, one the decoded configuration.
module pswc_sync_ff #(
    parameter int         WIDTH = 1,
    parameter logic [WIDTH-1:0] RST = '0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);

    // Registers the value on every edge; reset gives the constant.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

endmodule // pswc_sync_ff

// *** tb/pswc_ctrl_model.sv ***
// ------------------------------------------------------------------
// Memory controller model: register port master and pin driver.
// ------------------------------------------------------------------
module pswc_ctrl_model #(
    parameter logic [1:0] SUPPLY = 2'h1
) (
    input  wire logic       clk,
    output      logic [3:0] reg_addr,
    output      logic [3:0] reg_wdata,
    output      logic       reg_write,
    output      logic       reg_read,
    output      logic [3:0] cs_n,
    output      logic       cke0,
    output      logic       cke1,
    output      logic [1:0] odt
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels at time zero: no strobe, DRAM deselected, clock enables high.
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        cs_n = 4'hF;
        cke0 = 1'b1;
        cke1 = 1'b1;
        odt = 2'h0;
    end

    // One-cycle write strobe; the next call waits an edge, so no double assignment.
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_wdata <= ~d; // Stale data is scrambled so it cannot be reused.
    endtask

    // One-cycle read strobe; data are taken by the bench's monitor.
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
    endtask

    // Pin levels change just after a rising edge.
    task automatic pins(input logic [3:0] c, input logic k0, input logic k1, input logic [1:0] o);
        @(posedge clk);
        cs_n <= c;
        cke0 <= k0;
        cke1 <= k1;
        odt <= o;
    endtask

    // The voltage word always matches the supply actually fitted.
    task automatic set_supply();
        wr(pswc_pkg::ADDR_SUPPLY_VOLTAGE, {2'b01, SUPPLY});
    endtask
endmodule // pswc_ctrl_model

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, reset_n, reg_write, reg_read, cke0, cke1, rd_seen;
    logic [3:0] reg_addr, reg_wdata, reg_rdata, cs_n, v;
    logic [1:0] odt, odt_out, ca_drive, ctrl_drive, clk_drive, supply_mode;
    logic       ca_oe_n, term, pd, speed_valid, supply_valid, ca_ref;
    logic [2:0] speed_code;
    logic [31:0] seed = 32'h3;
    logic [31:0] r;
    logic [7:0] notes[$];
    logic [7:0] note;
    int         n_errors = 0;
    int         n_checks = 0;

    pswc_ctrl_words uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .chip_select_in_n(cs_n), .clk_enable_in0(cke0),
        .clk_enable_in1(cke1), .odt_in(odt), .odt_out(odt_out), .ca_out_enable_n(ca_oe_n),
        .ca_drive(ca_drive), .ctrl_drive(ctrl_drive), .clk_drive(clk_drive),
        .input_termination(term), .power_down(pd), .speed_code(speed_code),
        .speed_valid(speed_valid), .supply_mode(supply_mode), .supply_valid(supply_valid),
        .ca_reference_voltage(ca_ref));

    pswc_ctrl_model ctl (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .cs_n(cs_n), .cke0(cke0),
        .cke1(cke1), .odt(odt));

    // ------------------------------------------------------------------
    // Clock, reset and helpers.
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Word updates land two edges after the strobe; three leave margin.
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // Pin-driven outputs follow one edge after the pins change.
    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe; compare under the noted mask.
    always @(posedge clk) rd_seen <= reg_read;
    always @(negedge clk) begin
        if (rd_seen === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            chk({4'h0, reg_rdata & note[7:4]}, {4'h0, note[3:0]});
        end
    end

    initial begin
        repeat (4000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({6'h0, pd, term}, 8'h01);
        chk({5'h0, speed_code}, 8'h00);
        // Every speed code, with the ignored top bit randomised.
        for (int i = 0; i < 8; i++) begin
            r = xs();
            ctl.wr(pswc_pkg::ADDR_OPERATING_SPEED, {r[0], 3'(i)});
            settle();
            chk({5'h0, speed_code}, 8'(i));
            chk({7'h0, speed_valid}, 8'(i < 6));
        end
        // Every voltage word value, reserved ones included.
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            ctl.wr(pswc_pkg::ADDR_SUPPLY_VOLTAGE, v);
            settle();
            chk({6'h0, supply_mode}, {6'h0, v[1:0]});
            chk({7'h0, supply_valid}, 8'(v[1:0] != 2'h3));
            chk({7'h0, ca_ref}, {7'h0, v[2]});
        end
        ctl.set_supply();
        // Idle CA outputs: normal, then float, then weak.
        ctl.wr(pswc_pkg::ADDR_CA_DRIVE, 4'h2);
        ctl.wr(pswc_pkg::ADDR_OUTPUT_CONTROL0, 4'h0);
        ctl.pins(4'hF, 1'b1, 1'b1, 2'h0);
        settle();
        chk({5'h0, ca_oe_n, ca_drive}, 8'h02);
        ctl.wr(pswc_pkg::ADDR_OUTPUT_CONTROL0, 4'h2);
        ctl.wr(pswc_pkg::ADDR_POWER_SAVING, 4'h0);
        settle();
        chk({7'h0, ca_oe_n}, 8'h01);
        ctl.pins(4'hE, 1'b1, 1'b1, 2'h0);
        settle();
        chk({5'h0, ca_oe_n, ca_drive}, 8'h02);
        ctl.pins(4'hF, 1'b1, 1'b1, 2'h0);
        ctl.wr(pswc_pkg::ADDR_POWER_SAVING, 4'h1);
        settle();
        chk({5'h0, ca_oe_n, ca_drive}, {6'h0, pswc_pkg::DRIVE_WEAK});
        chk({4'h0, ctrl_drive, clk_drive}, 8'h00);
        // Power down disabled: both enables low change nothing.
        r = xs() | 32'h1; // Nonzero ODT, so a held-low output shows.
        ctl.wr(pswc_pkg::ADDR_POWER_SAVING, 4'h4);
        ctl.pins(4'hF, 1'b0, 1'b0, r[1:0]);
        settle();
        chk({6'h0, pd, term}, 8'h01);
        ctl.pins(4'hF, 1'b0, 1'b1, r[1:0]);
        ctl.wr(pswc_pkg::ADDR_POWER_SAVING, 4'h8);
        settle();
        chk({7'h0, pd}, 8'h00);
        ctl.pins(4'hF, 1'b0, 1'b0, r[1:0]);
        step();
        chk({5'h0, pd, term, 1'b0}, 8'h06);
        chk({6'h0, odt_out}, {6'h0, r[1:0]});
        ctl.wr(pswc_pkg::ADDR_POWER_SAVING, 4'hC);
        settle();
        chk({5'h0, pd, term, 1'b0}, 8'h04);
        chk({6'h0, odt_out}, 8'h00);
        // Status, a write-only word and an unmapped place, one idle cycle between strobes.
        notes.push_back(8'hF5);
        notes.push_back(8'hF0);
        notes.push_back(8'hF0);
        ctl.rd(pswc_pkg::ADDR_STATUS);
        ctl.rd(pswc_pkg::ADDR_SUPPLY_VOLTAGE);
        ctl.rd(4'hF);
        repeat (2) @(posedge clk);
        chk(8'(notes.size()), 8'h00);
        ctl.pins(4'hF, 1'b0, 1'b1, r[1:0]);
        step();
        chk({6'h0, pd, term}, 8'h01);
        step();
        chk({6'h0, odt_out}, {6'h0, r[1:0]});
        complete_run();
    end
endmodule // testbench
